// [verilog/prc_pkg.sv]
`default_nettype none
package prc_pkg;
    // Register offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    // Control field positions
    localparam int MRM_LSB = 4;
    localparam int MRL_LSB = 6;
    localparam int MR_LSB  = 8;
    localparam int SDR_BIT = 10;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic       SDR_RST  = 1'b0;
    // Prefetch mode encodings
    localparam logic [1:0] PF_LINE     = 2'h0;
    localparam logic [1:0] PF_FULL_ONE = 2'h1;
    localparam logic [1:0] PF_FULL     = 2'h2;
    localparam logic [1:0] PF_FULL_ALL = 2'h3;
    // Status field positions
    localparam int ST_STATE_LSB = 0;
    localparam int ST_REM_LSB   = 8;
    localparam int ST_KEEP_BIT  = 16;
    localparam int ST_CMD_LSB   = 17;
    localparam logic [31:0] ADDR_STEP = 32'h4;

    typedef enum logic [1:0] {CMD_MR, CMD_MRL, CMD_MRM} prc_cmd_t;

    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_READY, ST_XFER, ST_HOLD} prc_state_t;

    typedef struct packed {
        logic       sdr_en;
        logic [1:0] mr_mode;
        logic [1:0] mrl_mode;
        logic [1:0] mrm_mode;
    } prc_ctrl_t;

    typedef struct packed {
        prc_cmd_t    cmd;
        logic [31:0] addr;
        logic        pref;
    } prc_req_t;
endpackage
`default_nettype wire

// [verilog/prc_policy.sv]
`timescale 1ns/1ns
`default_nettype none
module prc_policy #(
    parameter int LEN_W   = 8,
    parameter int LINE_DW = 8,
    parameter int FULL_DW = 64
) (
    input  wire prc_pkg::prc_req_t  req,
    input  wire prc_pkg::prc_ctrl_t ctrl,
    output logic [LEN_W-1:0]        len,
    output logic                    keep_dev,
    output logic                    keep_mst,
    output logic                    disc_first
);
    import prc_pkg::*;

    localparam logic [LEN_W-1:0] LEN_ONE  = LEN_W'(1);
    localparam logic [LEN_W-1:0] LEN_LINE = LEN_W'(LINE_DW);
    localparam logic [LEN_W-1:0] LEN_FULL = LEN_W'(FULL_DW);

    always_comb
    begin
        len        = LEN_ONE;
        keep_dev   = 1'b0;
        keep_mst   = 1'b0;
        disc_first = 1'b0;
        if (req.pref)
        begin
            unique case (req.cmd)
                CMD_MRM:
                begin
                    len      = (ctrl.mrm_mode == PF_LINE) ? LEN_LINE : LEN_FULL;
                    keep_dev = ctrl.mrm_mode == PF_FULL_ONE || ctrl.mrm_mode == PF_FULL_ALL;
                    keep_mst = ctrl.mrm_mode == PF_FULL_ALL;
                end
                CMD_MRL:
                begin
                    len      = (ctrl.mrl_mode == PF_LINE) ? LEN_LINE : LEN_FULL;
                    keep_mst = ctrl.mrl_mode == PF_FULL_ONE || ctrl.mrl_mode == PF_FULL_ALL;
                    keep_dev = ctrl.mrl_mode == PF_FULL_ALL;
                end
                CMD_MR:
                begin
                    // Reserved code behaves as one line, the safe choice
                    unique case (ctrl.mr_mode)
                        PF_LINE:     len = LEN_LINE;
                        PF_FULL_ONE: len = LEN_LINE;
                        PF_FULL:     len = LEN_FULL;
                        PF_FULL_ALL:
                        begin
                            len        = LEN_ONE;
                            disc_first = 1'b1;
                        end
                    endcase
                end
                default: len = LEN_ONE;
            endcase
        end
        // Non-prefetchable: only the requested word, never kept
    end
endmodule
`default_nettype wire

// [verilog/prc_ctrl.sv]
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module prc_ctrl #(
    parameter int LEN_W   = 8,
    parameter int LINE_DW = 8,
    parameter int FULL_DW = 64
) (
    input  wire logic               REF_CLK,
    input  wire logic               RESET,
    input  wire logic [7:0]         REG_ADDR,
    input  wire logic [31:0]        REG_WDATA,
    input  wire logic               REG_WR,
    input  wire logic               REG_RD,
    output logic [31:0]             REG_RDATA,
    input  wire logic               REQ_VALID,
    input  wire prc_pkg::prc_req_t  REQ,
    output logic                    REQ_RETRY,
    output logic                    REQ_GRANT,
    output logic                    DISC_FIRST,
    output logic                    FETCH_VALID,
    output logic [31:0]             FETCH_ADDR,
    output logic [LEN_W-1:0]        FETCH_LEN,
    input  wire logic               FETCH_DONE,
    input  wire logic               DW_TAKEN,
    input  wire logic               XFER_END,
    input  wire logic               XFER_BY_MASTER,
    input  wire logic               DISCARD_EXPIRE,
    output logic                    BUF_KEEP,
    output logic                    BUF_FLUSH
);
    import prc_pkg::*;

    prc_ctrl_t        ctrl_q;
    prc_state_t       state_q;
    prc_req_t         pend_q;
    prc_req_t         pol_req;
    logic [31:0]      cur_addr_q;
    logic [LEN_W-1:0] rem_q;
    logic [LEN_W-1:0] rem_n;
    logic             keep_dev_q;
    logic             keep_mst_q;
    logic             disc_first_q;
    logic [LEN_W-1:0] pol_len;
    logic             pol_keep_dev;
    logic             pol_keep_mst;
    logic             pol_disc;
    logic             cmd_ok;
    logic             hit_ready;
    logic             hit_hold;
    logic             keep_now;
    logic [31:0]      status_w;

    // Policy looks at the new request while idle, else the pending one
    assign pol_req = (state_q == ST_IDLE) ? REQ : pend_q;

    prc_policy #(
        .LEN_W   (LEN_W),
        .LINE_DW (LINE_DW),
        .FULL_DW (FULL_DW)
    ) u_policy (
        .req        (pol_req),
        .ctrl       (ctrl_q),
        .len        (pol_len),
        .keep_dev   (pol_keep_dev),
        .keep_mst   (pol_keep_mst),
        .disc_first (pol_disc)
    );

    // Register writes
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            ctrl_q.mrm_mode <= MODE_RST;
            ctrl_q.mrl_mode <= MODE_RST;
            ctrl_q.mr_mode  <= MODE_RST;
            ctrl_q.sdr_en   <= SDR_RST;
        end
        else if (REG_WR && REG_ADDR == CTRL_OFS)
        begin
            ctrl_q.mrm_mode <= REG_WDATA[MRM_LSB +: 2];
            ctrl_q.mrl_mode <= REG_WDATA[MRL_LSB +: 2];
            ctrl_q.mr_mode  <= REG_WDATA[MR_LSB +: 2];
            ctrl_q.sdr_en   <= REG_WDATA[SDR_BIT];
        end
    end

    always_comb
    begin
        status_w = 32'h0;
        status_w[ST_STATE_LSB +: 3]   = state_q;
        status_w[ST_REM_LSB +: LEN_W] = rem_q;
        status_w[ST_KEEP_BIT]         = BUF_KEEP;
        status_w[ST_CMD_LSB +: 2]     = pend_q.cmd;
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            REG_RDATA <= 32'h0;
        else if (REG_RD)
        begin
            unique case (REG_ADDR)
                CTRL_OFS:
                begin
                    REG_RDATA <= 32'h0;
                    REG_RDATA[MRM_LSB +: 2] <= ctrl_q.mrm_mode;
                    REG_RDATA[MRL_LSB +: 2] <= ctrl_q.mrl_mode;
                    REG_RDATA[MR_LSB +: 2]  <= ctrl_q.mr_mode;
                    REG_RDATA[SDR_BIT]      <= ctrl_q.sdr_en;
                end
                STATUS_OFS: REG_RDATA <= status_w;
                default:    REG_RDATA <= 32'h0;
            endcase
        end
        else
            REG_RDATA <= 32'h0;
    end

    // Command match for a repeated delayed read
    assign cmd_ok    = (REQ.cmd == pend_q.cmd) || ctrl_q.sdr_en;
    // Completion relies on the master repeating the same address
    assign hit_ready = REQ_VALID && REQ.addr == pend_q.addr && cmd_ok;
    assign hit_hold  = REQ_VALID && REQ.addr == cur_addr_q && cmd_ok;
    assign rem_n     = (DW_TAKEN && rem_q != '0) ? rem_q - LEN_W'(1) : rem_q;
    assign keep_now  = XFER_BY_MASTER ? keep_mst_q : keep_dev_q;

    // Delayed-read sequencing
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            state_q <= ST_IDLE;
        else
        begin
            unique case (state_q)
                ST_IDLE:
                    if (REQ_VALID)
                        state_q <= ST_FETCH;
                ST_FETCH:
                    if (FETCH_DONE)
                        state_q <= ST_READY;
                ST_READY:
                    if (DISCARD_EXPIRE)
                        state_q <= ST_IDLE;
                    else if (hit_ready)
                        state_q <= ST_XFER;
                ST_XFER:
                    if (XFER_END)
                        state_q <= (keep_now && rem_n != '0) ? ST_HOLD : ST_IDLE;
                ST_HOLD:
                    // Expiry beats a late hit; that master is retried
                    if (DISCARD_EXPIRE)
                        state_q <= ST_IDLE;
                    else if (hit_hold)
                        state_q <= ST_XFER;
            endcase
        end
    end

    // Pending request and prefetch plan, latched when taken
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            pend_q       <= '{cmd: CMD_MR, addr: 32'h0, pref: 1'b0};
            keep_dev_q   <= 1'b0;
            keep_mst_q   <= 1'b0;
            disc_first_q <= 1'b0;
        end
        else if (state_q == ST_IDLE && REQ_VALID)
        begin
            pend_q       <= REQ;
            keep_dev_q   <= pol_keep_dev;
            keep_mst_q   <= pol_keep_mst;
            disc_first_q <= pol_disc;
        end
    end

    // Upstream fetch request, held until the data have landed
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            FETCH_VALID <= 1'b0;
            FETCH_ADDR  <= 32'h0;
            FETCH_LEN   <= '0;
        end
        else if (state_q == ST_IDLE && REQ_VALID)
        begin
            FETCH_VALID <= 1'b1;
            FETCH_ADDR  <= REQ.addr;
            FETCH_LEN   <= pol_len;
        end
        else if (state_q == ST_FETCH && FETCH_DONE)
            FETCH_VALID <= 1'b0;
    end

    // Words left in the queue and the address of the next one
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            rem_q      <= '0;
            cur_addr_q <= 32'h0;
        end
        else if (state_q == ST_FETCH && FETCH_DONE)
        begin
            rem_q      <= FETCH_LEN;
            cur_addr_q <= pend_q.addr;
        end
        else if (state_q == ST_XFER)
        begin
            rem_q <= rem_n;
            if (DW_TAKEN)
                cur_addr_q <= cur_addr_q + ADDR_STEP;
        end
        else if (state_q == ST_IDLE)
            rem_q <= '0;
    end

    // Answers to the master side
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            REQ_RETRY  <= 1'b0;
            REQ_GRANT  <= 1'b0;
            DISC_FIRST <= 1'b0;
        end
        else
        begin
            REQ_RETRY <= 1'b0;
            REQ_GRANT <= 1'b0;
            unique case (state_q)
                ST_IDLE, ST_FETCH:
                    REQ_RETRY <= REQ_VALID;
                ST_READY:
                begin
                    REQ_GRANT <= hit_ready && !DISCARD_EXPIRE;
                    REQ_RETRY <= REQ_VALID && !(hit_ready && !DISCARD_EXPIRE);
                end
                ST_HOLD:
                begin
                    REQ_GRANT <= hit_hold && !DISCARD_EXPIRE;
                    REQ_RETRY <= REQ_VALID && !(hit_hold && !DISCARD_EXPIRE);
                end
                ST_XFER:
                    REQ_RETRY <= REQ_VALID;
            endcase
            if ((state_q == ST_READY && hit_ready && !DISCARD_EXPIRE) ||
                (state_q == ST_HOLD && hit_hold && !DISCARD_EXPIRE))
                DISC_FIRST <= disc_first_q;
            else if (state_q == ST_XFER && XFER_END)
                DISC_FIRST <= 1'b0;
        end
    end

    // Leftover buffer ownership
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            BUF_KEEP  <= 1'b0;
            BUF_FLUSH <= 1'b0;
        end
        else
        begin
            BUF_FLUSH <= 1'b0;
            if (state_q == ST_XFER && XFER_END)
            begin
                BUF_KEEP  <= keep_now && rem_n != '0;
                BUF_FLUSH <= !(keep_now && rem_n != '0);
            end
            else if ((state_q == ST_HOLD || state_q == ST_READY) && DISCARD_EXPIRE)
            begin
                BUF_KEEP  <= 1'b0;
                BUF_FLUSH <= 1'b1;
            end
            else if (state_q == ST_HOLD && hit_hold)
                BUF_KEEP <= 1'b0;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    mrm_line_a: assert property ($rose(FETCH_VALID) && pend_q.pref && pend_q.cmd == CMD_MRM &&
        ctrl_q.mrm_mode == PF_LINE |-> FETCH_LEN == LEN_W'(LINE_DW))
        else $error("read multiple line fetch wrong");
    mrm_dev_keep_a: assert property (state_q == ST_XFER && XFER_END && !XFER_BY_MASTER &&
        pend_q.pref && pend_q.cmd == CMD_MRM && ctrl_q.mrm_mode == PF_FULL_ONE && rem_n != '0
        |=> BUF_KEEP && state_q == ST_HOLD)
        else $error("read multiple data not kept");
    mrm_all_keep_a: assert property (state_q == ST_XFER && XFER_END && XFER_BY_MASTER &&
        pend_q.pref && pend_q.cmd == CMD_MRM && ctrl_q.mrm_mode == PF_FULL_ALL && rem_n != '0
        |=> BUF_KEEP ##1 (BUF_KEEP || $past(DISCARD_EXPIRE) || $past(REQ_VALID)))
        else $error("read multiple leftover lost");
    mrl_line_a: assert property ($rose(FETCH_VALID) && pend_q.pref && pend_q.cmd == CMD_MRL &&
        ctrl_q.mrl_mode == PF_LINE |-> FETCH_LEN == LEN_W'(LINE_DW))
        else $error("read line fetch wrong");
    mrl_mst_keep_a: assert property (state_q == ST_XFER && XFER_END && XFER_BY_MASTER &&
        pend_q.pref && pend_q.cmd == CMD_MRL && ctrl_q.mrl_mode == PF_FULL_ONE && rem_n != '0
        |=> BUF_KEEP && !BUF_FLUSH)
        else $error("read line data not kept");
    mrl_all_keep_a: assert property (state_q == ST_XFER && XFER_END && !XFER_BY_MASTER &&
        pend_q.pref && pend_q.cmd == CMD_MRL && ctrl_q.mrl_mode == PF_FULL_ALL && rem_n != '0
        |=> BUF_KEEP)
        else $error("read line leftover lost");
    mr_full_a: assert property ($rose(FETCH_VALID) && pend_q.pref && pend_q.cmd == CMD_MR &&
        ctrl_q.mr_mode == PF_FULL |-> FETCH_LEN == LEN_W'(FULL_DW))
        else $error("plain read full fetch wrong");
    mr_first_dw_a: assert property (REQ_GRANT && pend_q.pref && pend_q.cmd == CMD_MR &&
        ctrl_q.mr_mode == PF_FULL_ALL |-> DISC_FIRST && FETCH_LEN == LEN_W'(1))
        else $error("first doubleword disconnect missing");
    cmd_change_a: assert property (state_q == ST_READY && REQ_VALID && !ctrl_q.sdr_en &&
        REQ.cmd != pend_q.cmd |=> REQ_RETRY && !REQ_GRANT)
        else $error("changed command not retried");
    sdr_accept_a: assert property (state_q == ST_READY && REQ_VALID && ctrl_q.sdr_en &&
        REQ.addr == pend_q.addr && !DISCARD_EXPIRE |=> REQ_GRANT && state_q == ST_XFER)
        else $error("special delayed read not completed");
    nonpref_a: assert property ($rose(FETCH_VALID) && !pend_q.pref |-> FETCH_LEN == LEN_W'(1))
        else $error("non-prefetchable read over-fetched");

    grant_c: cover property (state_q == ST_READY ##1 REQ_GRANT);
    hold_hit_c: cover property (state_q == ST_HOLD && hit_hold);
    expire_c: cover property (state_q == ST_HOLD && DISCARD_EXPIRE);
endmodule
`default_nettype wire

// [sim/prc_mst_model.sv]
`timescale 1ns/1ns
`default_nettype none
module prc_mst_model (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        req_retry,
    input  wire logic        req_grant,
    input  wire logic        fetch_valid,
    output logic             req_valid,
    output prc_pkg::prc_req_t req,
    output logic             dw_taken,
    output logic             xfer_end,
    output logic             xfer_by_master,
    output logic             fetch_done
);
    import prc_pkg::*;
    int         fetch_dly = 0;
    int         f_cnt;
    logic [1:0] f_st;
    initial
    begin
        req_valid = 1'b0;
        req = '0;
        dw_taken = 1'b0;
        xfer_end = 1'b0;
        xfer_by_master = 1'b0;
        fetch_done = 1'b0;
    end
    // Upstream side: slow or prompt completion, set per case
    always @(posedge ref_clk)
    begin
        fetch_done <= 1'b0;
        if (reset)
            f_st <= 2'h0;
        else if (f_st == 2'h0 && fetch_valid)
        begin
            f_st <= 2'h1;
            f_cnt <= fetch_dly;
        end
        else if (f_st == 2'h1 && f_cnt > 0)
            f_cnt <= f_cnt - 1;
        else if (f_st == 2'h1)
        begin
            fetch_done <= 1'b1;
            f_st <= 2'h2;
        end
        else if (f_st == 2'h2 && !fetch_valid)
            f_st <= 2'h0;
    end
    // One attempt; a retried caller comes back with the same address
    task automatic attempt(input prc_cmd_t c, input logic [31:0] a, input logic p, output logic g, output logic r);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req <= '{c, a, p};
        @(posedge ref_clk);
        req_valid <= 1'b0;
        // Released request shows garbage, not the old value
        req <= prc_req_t'(~req);
        #1;
        g = req_grant;
        r = req_retry;
    endtask
    task automatic burst(input int n, input logic bm);
        repeat (n)
        begin
            @(posedge ref_clk);
            dw_taken <= 1'b1;
        end
        @(posedge ref_clk);
        dw_taken <= 1'b0;
        xfer_end <= 1'b1;
        xfer_by_master <= bm;
        @(posedge ref_clk);
        xfer_end <= 1'b0;
        xfer_by_master <= ~bm;
    endtask
endmodule
`default_nettype wire

// [sim/tb_pci_read_prefetch_control.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_pci_read_prefetch_control;
    import prc_pkg::*;
    localparam int LINE = 8;
    localparam int FULL = 64;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        dexp = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] fetch_addr;
    logic [7:0]  fetch_len;
    logic        req_valid, req_retry, req_grant, disc_first, fetch_valid, fetch_done;
    logic        dw_taken, xfer_end, xfer_by_master, buf_keep, buf_flush;
    prc_req_t    req;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;
    logic [31:0] base = 32'h1000;
    logic [31:0] rd;
    logic        g, r;
    always #20 ref_clk = ~ref_clk;
    prc_ctrl #(.LEN_W(8), .LINE_DW(LINE), .FULL_DW(FULL)) i_dut (
        .REF_CLK(ref_clk), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REQ_VALID(req_valid),
        .REQ(req), .REQ_RETRY(req_retry), .REQ_GRANT(req_grant), .DISC_FIRST(disc_first),
        .FETCH_VALID(fetch_valid), .FETCH_ADDR(fetch_addr), .FETCH_LEN(fetch_len),
        .FETCH_DONE(fetch_done), .DW_TAKEN(dw_taken), .XFER_END(xfer_end),
        .XFER_BY_MASTER(xfer_by_master), .DISCARD_EXPIRE(dexp), .BUF_KEEP(buf_keep),
        .BUF_FLUSH(buf_flush)
    );
    prc_mst_model i_mst (
        .ref_clk(ref_clk), .reset(reset), .req_retry(req_retry), .req_grant(req_grant),
        .fetch_valid(fetch_valid), .req_valid(req_valid), .req(req), .dw_taken(dw_taken),
        .xfer_end(xfer_end), .xfer_by_master(xfer_by_master), .fetch_done(fetch_done)
    );
    task automatic chk_bit(input string n, input logic e, input logic s);
        total_checks++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %s expected %b seen %b", n, e, s);
        end
    endtask
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic wait_fetch;
        int i;
        i = 0;
        while (fetch_valid === 1'b1 && i < 100)
        begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        chk_bit("fetch_valid", 1'b0, fetch_valid);
    endtask
    task automatic run_case(input prc_cmd_t c, input prc_cmd_t c2, input logic [1:0] m, input logic sdr,
                            input logic p, input int len, input logic disc, input int n, input logic bm,
                            input logic keep);
        int lsb;
        lsb = (c == CMD_MRM) ? MRM_LSB : (c == CMD_MRL) ? MRL_LSB : MR_LSB;
        base = base + 32'h100;
        i_mst.fetch_dly = base[8] ? 9 : 0;
        reg_write(CTRL_OFS, (32'(m) << lsb) | (32'(sdr) << SDR_BIT));
        i_mst.attempt(c, base, p, g, r);
        chk_bit("first retry", 1'b1, r);
        chk_bit("first grant", 1'b0, g);
        chk_word("fetch addr", base, fetch_addr);
        chk_word("fetch len", 32'(len), {24'h0, fetch_len});
        i_mst.attempt(c, base, p, g, r);
        chk_bit("fetch retry", 1'b1, r);
        wait_fetch();
        reg_read(STATUS_OFS, rd);
        chk_word("state", 32'h2, {29'h0, rd[2:0]});
        if (c2 != c)
        begin
            i_mst.attempt(c2, base + 32'h4, p, g, r);
            chk_bit("addr miss", 1'b1, r);
        end
        i_mst.attempt(c2, base, p, g, r);
        if (c2 != c && !sdr)
        begin
            chk_bit("cmd change retry", 1'b1, r);
            i_mst.attempt(c, base, p, g, r);
        end
        chk_bit("grant", 1'b1, g);
        chk_bit("disc first", disc, disc_first);
        i_mst.burst(n, bm);
        #1;
        chk_bit("keep", keep, buf_keep);
        chk_bit("flush", !keep, buf_flush);
        if (keep)
        begin
            // Held data serve the next unread address
            i_mst.attempt(c, base + 32'(4 * n), p, g, r);
            chk_bit("hold hit", 1'b1, g);
            i_mst.burst(1, bm);
            #1;
            chk_bit("keep again", 1'b1, buf_keep);
            @(posedge ref_clk);
            dexp <= 1'b1;
            @(posedge ref_clk);
            dexp <= 1'b0;
            #1;
            chk_bit("expire flush", 1'b1, buf_flush);
            chk_bit("expire keep", 1'b0, buf_keep);
        end
        $display("case at %h done", base);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        reg_read(CTRL_OFS, rd);
        chk_word("ctrl reset", 32'h0, rd);
        reg_read(8'h08, rd);
        chk_word("unmapped", 32'h0, rd);
        reg_write(CTRL_OFS, 32'h7f0);
        reg_read(CTRL_OFS, rd);
        chk_word("ctrl back", 32'h7f0, rd);
        $display("register test done");
        run_case(CMD_MRM, CMD_MRM, 2'h0, 1'b0, 1'b1, LINE, 1'b0, 2, 1'b0, 1'b0);
        run_case(CMD_MRM, CMD_MRM, 2'h2, 1'b0, 1'b1, FULL, 1'b0, 2, 1'b0, 1'b0);
        run_case(CMD_MRM, CMD_MRM, 2'h1, 1'b0, 1'b1, FULL, 1'b0, 2, 1'b0, 1'b1);
        run_case(CMD_MRM, CMD_MRM, 2'h1, 1'b0, 1'b1, FULL, 1'b0, 2, 1'b1, 1'b0);
        run_case(CMD_MRM, CMD_MRM, 2'h3, 1'b0, 1'b1, FULL, 1'b0, 2, 1'b1, 1'b1);
        run_case(CMD_MRL, CMD_MRL, 2'h0, 1'b0, 1'b1, LINE, 1'b0, 2, 1'b1, 1'b0);
        run_case(CMD_MRL, CMD_MRL, 2'h1, 1'b0, 1'b1, FULL, 1'b0, 2, 1'b1, 1'b1);
        run_case(CMD_MRL, CMD_MRL, 2'h1, 1'b0, 1'b1, FULL, 1'b0, 2, 1'b0, 1'b0);
        run_case(CMD_MRL, CMD_MRL, 2'h3, 1'b0, 1'b1, FULL, 1'b0, 2, 1'b0, 1'b1);
        run_case(CMD_MRL, CMD_MRL, 2'h2, 1'b0, 1'b1, FULL, 1'b0, 2, 1'b1, 1'b0);
        run_case(CMD_MR, CMD_MR, 2'h0, 1'b0, 1'b1, LINE, 1'b0, 2, 1'b1, 1'b0);
        run_case(CMD_MR, CMD_MR, 2'h1, 1'b0, 1'b1, LINE, 1'b0, 2, 1'b1, 1'b0);
        run_case(CMD_MR, CMD_MR, 2'h2, 1'b0, 1'b1, FULL, 1'b0, 2, 1'b0, 1'b0);
        run_case(CMD_MR, CMD_MR, 2'h3, 1'b0, 1'b1, 1, 1'b1, 1, 1'b0, 1'b0);
        run_case(CMD_MR, CMD_MRL, 2'h0, 1'b0, 1'b1, LINE, 1'b0, 2, 1'b1, 1'b0);
        run_case(CMD_MRM, CMD_MR, 2'h0, 1'b1, 1'b1, LINE, 1'b0, 2, 1'b0, 1'b0);
        run_case(CMD_MRL, CMD_MRM, 2'h0, 1'b1, 1'b1, LINE, 1'b0, 2, 1'b1, 1'b0);
        run_case(CMD_MRM, CMD_MRM, 2'h3, 1'b0, 1'b0, 1, 1'b0, 1, 1'b1, 1'b0);
        // Expiry in ready wins over a hit in the same cycle
        i_mst.attempt(CMD_MR, 32'h4000, 1'b0, g, r);
        wait_fetch();
        fork
            i_mst.attempt(CMD_MR, 32'h4000, 1'b0, g, r);
            begin
                @(posedge ref_clk);
                dexp <= 1'b1;
                @(posedge ref_clk);
                dexp <= 1'b0;
            end
        join
        chk_bit("expire vs hit retry", 1'b1, r);
        chk_bit("expire vs hit grant", 1'b0, g);
        chk_bit("ready expire flush", 1'b1, buf_flush);
        $display("expiry test done");
        give_verdict();
    end
endmodule
`default_nettype wire
